// ---- verilog/mbox_cmd.sv ----
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
// mailbox command interpreter with avalon-mm register slave
module mbox_cmd
    import mbox_pkg::*;
#(
    parameter bit ODD_PORT = 1'b1
)(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // avalon-mm slave
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // line-side status pins (asynchronous)
    input wire logic autoneg_done_i,
    input wire logic training_i,
    input wire logic lr_linked_i,
    input wire logic [15:0] volt_a_i,
    input wire logic [15:0] volt_b_i,
    input wire logic [15:0] volt_c_i,
    input wire logic [63:0] snr_i,
    input wire logic [15:0] temp_i,
    // applied configuration
    output logic [7:0] lane_map_o,
    output logic ts_en_o,
    output logic lr_en_o,
    output logic lr_low_pwr_o,
    output lpi_cfg_type lpi_cfg_o,
    output logic emi_en_o,
    output logic fault_idle_o,
    output logic backplane_o,
    output taps_type taps0_o,
    output taps_type taps1_o,
    output logic [15:0] temp_warn_o
);
    typedef enum {S_IDLE, S_RECV, S_EXEC, S_DONE} state_type;
    state_type state_q;
    logic [15:0] cmd_q; // last command code
    logic [15:0] status_q; // status word
    logic [15:0] word_q [1:5]; // parameter words
    logic [1:0] speed_q; // link speed, software written
    logic [7:0] map_req_q; // requested lane map
    logic ts_q;
    logic lr_en_q;
    logic lr_pwr_q;
    logic emi_pend_q;
    logic f2i_q;
    logic bp_q;
    taps_type taps_q [0:1];
    lpi_cfg_type lpi_pend_q;
    logic an_meta_q, an_sync_q, an_prev_q; // autoneg sync
    logic tr_meta_q, tr_sync_q; // training sync
    logic lr_meta_q, lr_sync_q;
    logic [15:0] va_m, va_s, vb_m, vb_s, vc_m, vc_s, tp_m, tp_s;
    logic [63:0] snr_m, snr_s;
    logic ack_q; // one-cycle bus answer
    logic an_pulse;
    logic go;
    logic cmd_ok;

    // two-stage synchronisers for line inputs
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {an_meta_q, an_sync_q, an_prev_q} <= 3'h0;
            {tr_meta_q, tr_sync_q, lr_meta_q, lr_sync_q} <= 4'h0;
            {va_m, va_s, vb_m, vb_s} <= '0;
            {vc_m, vc_s, tp_m, tp_s} <= '0;
            {snr_m, snr_s} <= '0;
        end else begin
            an_meta_q <= autoneg_done_i;
            an_sync_q <= an_meta_q;
            an_prev_q <= an_sync_q;
            tr_meta_q <= training_i;
            tr_sync_q <= tr_meta_q;
            lr_meta_q <= lr_linked_i;
            lr_sync_q <= lr_meta_q;
            va_m <= volt_a_i;
            va_s <= va_m;
            vb_m <= volt_b_i;
            vb_s <= vb_m;
            vc_m <= volt_c_i;
            vc_s <= vc_m;
            tp_m <= temp_i;
            tp_s <= tp_m;
            snr_m <= snr_i;
            snr_s <= snr_m;
        end
    end

    // rising edge of autoneg completion
    assign an_pulse = an_sync_q && !an_prev_q;

    // a command write with bit 15 set while open for commands
    // writes commit at the edge where waitrequest is seen low (ack_q high)
    assign go = avs_write_i && ack_q && avs_address_i == ADDR_CMD
        && avs_byteenable_i[1] && avs_writedata_i[15]
        && state_q == S_IDLE && !tr_sync_q;

    // known command check
    always_comb begin
        case (cmd_q)
            C_GET_MAP, C_SET_MAP, C_GET_TS, C_SET_TS, C_GET_LR, C_SET_LR,
            C_GET_LPI, C_SET_LPI, C_GET_EMI, C_SET_EMI, C_GET_F2I, C_GET_BP,
            C_SET_BP, C_DIS_F2I, C_ENA_F2I, C_GET_TAPS, C_SET_TAPS,
            C_GET_VOLT, C_GET_TEMP, C_SET_UPW, C_GET_UPW: cmd_ok = 1'b1;
            C_GET_SNR: cmd_ok = (word_q[1] == 16'h0000);
            default: cmd_ok = 1'b0;
        endcase
    end

    // bus answer: every access completes one cycle after it is seen
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read_i || avs_write_i) && !ack_q;
        end
    end
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack_q);
        end
    end

    // read data mux, unmapped reads zero
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            avs_readdata_o <= '0;
        end else if (avs_read_i && !ack_q) begin
            case (avs_address_i)
                ADDR_CMD: avs_readdata_o <= {16'h0000, cmd_q};
                ADDR_STATUS: avs_readdata_o <= {16'h0000, tr_sync_q ? ST_BUSY
                                                : status_q};
                ADDR_WORD1: avs_readdata_o <= {16'h0000, word_q[1]};
                6'h0C: avs_readdata_o <= {16'h0000, word_q[2]};
                6'h10: avs_readdata_o <= {16'h0000, word_q[3]};
                6'h14: avs_readdata_o <= {16'h0000, word_q[4]};
                ADDR_WORD5: avs_readdata_o <= {16'h0000, word_q[5]};
                ADDR_SPEED: avs_readdata_o <= {30'h0, speed_q};
                default: avs_readdata_o <= '0;
            endcase
        end
    end

    // command sequencer
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= S_IDLE;
            status_q <= ST_PASS;
            cmd_q <= 16'h0000;
        end else begin
            case (state_q)
                S_IDLE: if (go) begin
                    cmd_q <= avs_writedata_i[15:0];
                    status_q <= ST_RECEIVED;
                    state_q <= S_RECV;
                end else if (avs_write_i && ack_q && avs_address_i == ADDR_STATUS) begin
                    status_q <= avs_writedata_i[15:0]; // status is host-writable
                end
                S_RECV: begin
                    status_q <= ST_PROGRESS;
                    state_q <= S_EXEC;
                end
                S_EXEC: begin
                    status_q <= cmd_ok ? ST_PASS : ST_ERROR;
                    state_q <= S_DONE;
                end
                S_DONE: state_q <= S_IDLE;
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // parameter words: host writes while idle, results on execute
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 1; i <= 5; i++) word_q[i] <= 16'h0000;
        end else if (state_q == S_EXEC && cmd_ok) begin
            for (int i = 1; i <= 5; i++) word_q[i] <= 16'h0000;
            case (cmd_q)
                C_GET_MAP: begin
                    word_q[1] <= {8'h00, map_req_q};
                    word_q[2] <= {8'h00, lane_map_o};
                end
                C_GET_TS: word_q[1] <= {15'h0, ts_q};
                C_GET_LR: begin
                    word_q[1] <= {15'h0, lr_en_q};
                    word_q[2] <= {15'h0, lr_en_q && lr_pwr_q};
                    word_q[3] <= {15'h0, lr_en_q && lr_sync_q};
                end
                C_GET_LPI: begin
                    word_q[1] <= {8'h00, lpi_pend_q.modes};
                    word_q[2] <= lpi_pend_q.high_thr;
                    word_q[3] <= lpi_pend_q.low_thr;
                    word_q[4] <= lpi_pend_q.latency;
                end
                C_GET_EMI: word_q[1] <= {15'h0, emi_pend_q};
                C_GET_F2I: word_q[1] <= {15'h0, f2i_q};
                C_GET_BP: word_q[1] <= {15'h0, bp_q};
                C_GET_TAPS: begin
                    word_q[1] <= word_q[1]; // port select echoed
                    word_q[2] <= taps_q[word_q[1][0]].pre_main;
                    word_q[3] <= taps_q[word_q[1][0]].post;
                    word_q[4] <= {8'h00, taps_q[word_q[1][0]].post3};
                end
                C_GET_VOLT: begin
                    word_q[1] <= va_s;
                    word_q[2] <= vb_s;
                    word_q[3] <= vc_s;
                end
                C_GET_SNR: begin
                    word_q[2] <= snr_s[15:0];
                    word_q[3] <= snr_s[31:16];
                    word_q[4] <= snr_s[47:32];
                    word_q[5] <= snr_s[63:48];
                end
                C_GET_TEMP: word_q[1] <= tp_s;
                C_GET_UPW: word_q[1] <= temp_warn_o;
                default: for (int i = 1; i <= 5; i++) word_q[i] <= word_q[i];
            endcase
        end else if (avs_write_i && ack_q && state_q == S_IDLE) begin
            case (avs_address_i)
                ADDR_WORD1: word_q[1] <= avs_writedata_i[15:0];
                6'h0C: word_q[2] <= avs_writedata_i[15:0];
                6'h10: word_q[3] <= avs_writedata_i[15:0];
                6'h14: word_q[4] <= avs_writedata_i[15:0];
                ADDR_WORD5: word_q[5] <= avs_writedata_i[15:0];
                default: ;
            endcase
        end
    end

    // speed register written by software
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            speed_q <= SPD_10G;
        end else if (avs_write_i && ack_q && avs_address_i == ADDR_SPEED) begin
            speed_q <= avs_writedata_i[1:0];
        end
    end

    // set commands: stored settings
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            map_req_q <= ODD_PORT ? MAP_ODD_RST : MAP_EVEN_RST;
            ts_q <= 1'b0;
            lr_en_q <= 1'b0;
            lr_pwr_q <= 1'b0;
            emi_pend_q <= 1'b0;
            f2i_q <= 1'b0;
            bp_q <= 1'b0;
            taps_q[0] <= '0;
            taps_q[1] <= '0;
            temp_warn_o <= 16'h0000;
            lpi_pend_q <= '{modes: 8'h00, high_thr: HIGH_THR_RST,
                            low_thr: LOW_THR_RST, latency: LATENCY_RST};
        end else if (state_q == S_EXEC) begin
            case (cmd_q)
                C_SET_MAP: map_req_q <= word_q[2][7:0];
                C_SET_TS: ts_q <= word_q[1][0];
                C_SET_LR: begin
                    lr_en_q <= word_q[1][0];
                    lr_pwr_q <= word_q[2][0];
                end
                C_SET_LPI: begin
                    lpi_pend_q.modes <= word_q[1][7:0];
                    // variable latency not valid at 1G/100M: keep fixed
                    if (word_q[1][SPD_1G_LSB +: 2] == MODE_VARLAT) begin
                        lpi_pend_q.modes[SPD_1G_LSB +: 2] <= lpi_pend_q.modes[SPD_1G_LSB +: 2];
                    end
                    lpi_pend_q.high_thr <= word_q[2];
                    lpi_pend_q.low_thr <= word_q[3];
                    lpi_pend_q.latency <= word_q[4];
                end
                C_SET_EMI: emi_pend_q <= word_q[1][0];
                C_ENA_F2I: f2i_q <= 1'b1;
                C_DIS_F2I: f2i_q <= 1'b0;
                C_SET_BP: bp_q <= word_q[1][0];
                C_SET_TAPS: taps_q[word_q[1][0]] <= '{post3: word_q[4][7:0],
                    post: word_q[3], pre_main: word_q[2]};
                C_SET_UPW: temp_warn_o <= word_q[1];
                default: ;
            endcase
        end
    end

    // settings that wait for autonegotiation
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lane_map_o <= ODD_PORT ? MAP_ODD_RST : MAP_EVEN_RST;
            emi_en_o <= 1'b0;
            ts_en_o <= 1'b0;
        end else if (an_pulse) begin
            lane_map_o <= map_req_q;
            emi_en_o <= emi_pend_q;
            ts_en_o <= ts_q;
        end
    end

    // immediately applied settings
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {lr_en_o, lr_low_pwr_o, fault_idle_o, backplane_o} <= 4'h0;
            taps0_o <= '0;
            taps1_o <= '0;
        end else begin
            lr_en_o <= lr_en_q;
            lr_low_pwr_o <= lr_pwr_q;
            fault_idle_o <= f2i_q;
            backplane_o <= bp_q;
            taps0_o <= taps_q[0];
            taps1_o <= taps_q[1];
        end
    end

    // applied power mode configuration
    lpi_apply u_lpi (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .pend_i(lpi_pend_q),
        .apply_i(an_pulse),
        .speed_i(speed_q),
        .eff_o(lpi_cfg_o)
    );
endmodule : mbox_cmd

// ---- verilog/mbox_pkg.sv ----
// Operation
// - get mapping returns requested in word1, active in word2
// - set mapping forced from word2, applied after autoneg
// - odd port selectors D,C,B,A from high bits
// - even port selectors reversed, codes inverted
// - timestamp enable stored and returned in word1
// - limited reach returns enable, power, link state
// - word1 holds four 2-bit per-speed power modes
// - shared thresholds and latency with stated defaults
// - speed-dependent ignoring of adaptive words
// - new power mode applies after autonegotiation
// - emission cancel stored, applied after autonegotiation
// - fault-to-idle enable, disable and query
// - backplane mode set and read in word1
// - transmit taps per serial port in words 2-4
// - voltage readout in words 1 to 3
// - snr query needs word1 zero, returns words 2-5
// - temperature query returns die temperature
// - set upper warning stores word1 value
// - bit 15 command write drives status sequence
// - status codes received, progress, pass, error, busy
package mbox_pkg;
    // register byte addresses on the avalon bus
    localparam logic [5:0] ADDR_CMD = 6'h00;
    localparam logic [5:0] ADDR_STATUS = 6'h04;
    localparam logic [5:0] ADDR_WORD1 = 6'h08;
    localparam logic [5:0] ADDR_WORD5 = 6'h18;
    localparam logic [5:0] ADDR_SPEED = 6'h1C;
    localparam int WORD_W = 16;
    // command codes
    localparam logic [15:0] CMD_GO_BIT = 16'h8000;
    localparam logic [15:0] C_GET_MAP = 16'h8000;
    localparam logic [15:0] C_SET_MAP = 16'h8001;
    localparam logic [15:0] C_GET_TS = 16'h8004;
    localparam logic [15:0] C_SET_TS = 16'h8005;
    localparam logic [15:0] C_GET_LR = 16'h8006;
    localparam logic [15:0] C_SET_LR = 16'h8007;
    localparam logic [15:0] C_GET_LPI = 16'h8008;
    localparam logic [15:0] C_SET_LPI = 16'h8009;
    localparam logic [15:0] C_GET_EMI = 16'h800A;
    localparam logic [15:0] C_SET_EMI = 16'h800B;
    localparam logic [15:0] C_GET_F2I = 16'h800D;
    localparam logic [15:0] C_GET_BP = 16'h800E;
    localparam logic [15:0] C_SET_BP = 16'h800F;
    localparam logic [15:0] C_DIS_F2I = 16'h8010;
    localparam logic [15:0] C_ENA_F2I = 16'h8011;
    localparam logic [15:0] C_GET_TAPS = 16'h802B;
    localparam logic [15:0] C_SET_TAPS = 16'h802C;
    localparam logic [15:0] C_GET_VOLT = 16'h802F;
    localparam logic [15:0] C_GET_SNR = 16'h8030;
    localparam logic [15:0] C_GET_TEMP = 16'h8031;
    localparam logic [15:0] C_SET_UPW = 16'h8032;
    localparam logic [15:0] C_GET_UPW = 16'h8033;
    // status codes
    localparam logic [15:0] ST_RECEIVED = 16'h0001;
    localparam logic [15:0] ST_PROGRESS = 16'h0002;
    localparam logic [15:0] ST_PASS = 16'h0004;
    localparam logic [15:0] ST_ERROR = 16'h0008;
    localparam logic [15:0] ST_BUSY = 16'hBBBB;
    // reset values
    localparam logic [15:0] LOW_THR_RST = 16'h7A12;
    localparam logic [15:0] LATENCY_RST = 16'h047E;
    localparam logic [15:0] HIGH_THR_RST = 16'h0000;
    localparam logic [7:0] MAP_ODD_RST = 8'hE4;
    localparam logic [7:0] MAP_EVEN_RST = 8'h1B;
    localparam logic [7:0] BYTE_MASK = 8'hFF;
    localparam logic [1:0] MODE_VARLAT = 2'h3;
    localparam int SPD_1G_LSB = 2;
    // link speed encoding
    localparam logic [1:0] SPD_10G = 2'h0;
    localparam logic [1:0] SPD_5G = 2'h1;
    localparam logic [1:0] SPD_2G5 = 2'h2;
    localparam logic [1:0] SPD_1G = 2'h3;
    // applied low power idle configuration
    typedef struct packed {
        logic [7:0] modes;
        logic [15:0] high_thr;
        logic [15:0] low_thr;
        logic [15:0] latency;
    } lpi_cfg_type;
    // per-port serial transmit taps
    typedef struct packed {
        logic [7:0] post3;
        logic [15:0] post;
        logic [15:0] pre_main;
    } taps_type;
endpackage : mbox_pkg

// ---- verilog/lpi_apply.sv ----
`timescale 1ns/10ps
// holds the applied power mode set and masks words by speed
module lpi_apply
    import mbox_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // pending configuration and apply strobe
    input wire lpi_cfg_type pend_i,
    input wire logic apply_i,
    input wire logic [1:0] speed_i,
    // effective configuration
    output lpi_cfg_type eff_o
);
    lpi_cfg_type act_q; // configuration taken at last autoneg

    // latch pending set only on autoneg completion
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            act_q <= '{modes: 8'h00, high_thr: HIGH_THR_RST,
                       low_thr: LOW_THR_RST, latency: LATENCY_RST};
        end else if (apply_i) begin
            act_q <= pend_i;
        end
    end

    // speed dependent masking of adaptive words, registered
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            eff_o <= '0;
        end else begin
            eff_o <= act_q;
            case (speed_i)
                SPD_10G: begin
                    eff_o.high_thr <= '0;
                    eff_o.low_thr <= '0;
                    eff_o.latency <= '0;
                end
                SPD_5G: eff_o.latency <= '0;
                SPD_1G: begin
                    eff_o.high_thr <= '0;
                    eff_o.low_thr <= '0;
                    eff_o.latency <= '0;
                end
                default: ;
            endcase
        end
    end
endmodule : lpi_apply

// ---- sim/mbox_monitor.sv ----
`timescale 1ns/10ps
// port-level checks on the mailbox slave
module mbox_monitor
    import mbox_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // bus
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // line side and applied settings
    input wire logic autoneg_done_i,
    input wire logic [7:0] lane_map_o,
    input wire logic ts_en_o,
    input wire logic lr_en_o,
    input wire logic emi_en_o,
    input wire lpi_cfg_type lpi_cfg_o,
    input wire taps_type taps1_o,
    input wire logic [15:0] temp_warn_o
);
    // cycles since the last accepted write, saturating
    logic [3:0] since_wr_q;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // restart the count on every accepted write
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            since_wr_q <= 4'h0;
        end else if (avs_write_i && !avs_waitrequest_o) begin
            since_wr_q <= 4'h0;
        end else if (since_wr_q != 4'hF) begin
            since_wr_q <= since_wr_q + 4'h1;
        end
    end
    ans_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("answer held longer than one cycle");
    ans_bound_a: assert property ((avs_read_i || avs_write_i) |-> ##[0:2] !avs_waitrequest_o)
        else $error("request not answered in time");
    ans_cause_a: assert property (!avs_waitrequest_o |-> (avs_read_i || avs_write_i))
        else $error("answer without a request");
    upper_zero_a: assert property (avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    rd_cause_a: assert property ($changed(avs_readdata_o) |-> avs_read_i && !avs_waitrequest_o)
        else $error("read data moved without a read");
    apply_hold_a: assert property (!autoneg_done_i [*5] |=> $stable({lane_map_o, ts_en_o, emi_en_o, lpi_cfg_o.modes}))
        else $error("setting applied without autonegotiation");
    var_lat_a: assert property (lpi_cfg_o.modes[3:2] != MODE_VARLAT)
        else $error("variable latency on 1G field");
    cfg_cause_a: assert property (($changed(lr_en_o) || $changed(taps1_o) || $changed(temp_warn_o)) |-> since_wr_q < 4'h8)
        else $error("setting changed without a command");
    cover property (avs_write_i && !avs_waitrequest_o);
    cover property ($rose(ts_en_o));
    cover property ($changed(lane_map_o));
endmodule : mbox_monitor

bind mbox_cmd mbox_monitor mbox_monitor_i (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .autoneg_done_i(autoneg_done_i),
    .lane_map_o(lane_map_o), .ts_en_o(ts_en_o), .lr_en_o(lr_en_o), .emi_en_o(emi_en_o),
    .lpi_cfg_o(lpi_cfg_o), .taps1_o(taps1_o), .temp_warn_o(temp_warn_o)
);

// ---- sim/mbox_host.sv ----
`timescale 1ns/10ps
// management host: avalon-mm master that runs mailbox commands
module mbox_host
    import mbox_pkg::*;
(
    // clock
    input wire logic core_clk_i,
    // slave answer
    input wire logic waitrequest_i,
    input wire logic [31:0] readdata_i,
    // master request
    output logic [5:0] address_o,
    output logic read_o,
    output logic write_o,
    output logic [31:0] writedata_o
);
    // set when a bus or poll wait ran out
    logic hung = 1'b0;
    // idle bus at time zero
    initial begin
        address_o = 6'h00;
        read_o = 1'b0;
        write_o = 1'b0;
        writedata_o = 32'h0000_0000;
    end
    // one bus cycle held until waitrequest is seen low
    task automatic xfer(input logic [5:0] a, input logic wr, input logic [15:0] d,
                        output logic [15:0] q);
        int k;
        @(posedge core_clk_i);
        address_o <= a;
        write_o <= wr;
        read_o <= !wr;
        writedata_o <= {16'h0000, d};
        for (k = 0; k < 64; k++) begin
            @(posedge core_clk_i);
            if (!waitrequest_i) break;
        end
        if (k == 64) hung = 1'b1;
        q = readdata_i[15:0];
        write_o <= 1'b0;
        read_o <= 1'b0;
    endtask : xfer
    // parameters first, then the code, then poll to completion
    task automatic run_cmd(input logic [15:0] code, input logic [15:0] w1,
                           input logic [15:0] w2, output logic [15:0] st);
        logic [15:0] d;
        int k;
        xfer(ADDR_WORD1, 1'b1, w1, d);
        xfer(6'h0C, 1'b1, w2, d);
        xfer(ADDR_CMD, 1'b1, code, d);
        for (k = 0; k < 32; k++) begin
            xfer(ADDR_STATUS, 1'b0, 16'h0000, st);
            if (st == ST_PASS || st == ST_ERROR) break;
        end
        if (k == 32) hung = 1'b1;
    endtask : run_cmd
endmodule : mbox_host

// ---- sim/phy_mailbox_command_params_bench.sv ----
`timescale 1ns/10ps
`define CHK(nm, e, g) \
    begin \
        n_checks++; \
        if ((g) !== (e)) begin \
            err_total++; \
            $display("unexpected %s expected %0h seen %0h", nm, e, g); \
        end \
    end
// self-checking bench for the mailbox command interpreter
module phy_mailbox_command_params_bench
    import mbox_pkg::*;
;
    // one command case: inputs, expected status and result word
    typedef struct {
        logic [15:0] cmd;
        logic [15:0] w1;
        logic [15:0] w2;
        logic [5:0] adr;
        logic [15:0] st;
        logic [15:0] exp;
    } row_type;
    localparam logic [5:0] ST = ADDR_STATUS, W1 = ADDR_WORD1, W2 = 6'h0C, W3 = 6'h10;
    localparam logic [15:0] Z = 16'h0000, OK = ST_PASS, NG = ST_ERROR;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic autoneg = 1'b0;
    logic training = 1'b0;
    logic [47:0] volts = 48'h0377_0222_0111;
    logic [63:0] snr = 64'h0004_0003_0002_0001;
    logic [15:0] temp = 16'h0042;
    logic [5:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic waitrequest;
    lpi_cfg_type lpi_cfg;
    taps_type taps1;
    logic [7:0] lane_map;
    logic ts_en, lr_en, emi_en, fault_idle, backplane;
    logic [15:0] temp_warn;
    logic [15:0] q;
    int err_total = 0;
    int n_checks = 0;
    row_type rows [26];
    mbox_cmd mbox_cmd_i (
        .core_clk_i(core_clk), .rst_n_i(rst_n), .avs_address_i(address),
        .avs_read_i(read), .avs_write_i(write), .avs_writedata_i(writedata),
        .avs_byteenable_i(4'hF), .avs_readdata_o(readdata), .avs_waitrequest_o(waitrequest),
        .autoneg_done_i(autoneg), .training_i(training), .lr_linked_i(1'b1),
        .volt_a_i(volts[15:0]), .volt_b_i(volts[31:16]), .volt_c_i(volts[47:32]),
        .snr_i(snr), .temp_i(temp), .lane_map_o(lane_map), .ts_en_o(ts_en),
        .lr_en_o(lr_en), .lr_low_pwr_o(), .lpi_cfg_o(lpi_cfg), .emi_en_o(emi_en),
        .fault_idle_o(fault_idle), .backplane_o(backplane), .taps0_o(),
        .taps1_o(taps1), .temp_warn_o(temp_warn)
    );
    mbox_host mbox_host_i (
        .core_clk_i(core_clk), .waitrequest_i(waitrequest), .readdata_i(readdata),
        .address_o(address), .read_o(read), .write_o(write), .writedata_o(writedata)
    );
    // counts and verdict, then stop
    task automatic close_out();
        err_total += mbox_host_i.hung;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out
    always #2.5 core_clk = ~core_clk;
    // cut a hang short
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        close_out();
    end
    // main sequence
    initial begin
        rows = '{'{C_GET_LPI, Z, Z, W3, OK, 16'h7A12},
            '{C_GET_MAP, Z, Z, W2, OK, 16'h00E4},
            '{C_SET_MAP, Z, 16'h0039, ST, OK, OK},
            '{C_GET_MAP, Z, Z, W1, OK, 16'h0039},
            '{C_SET_TS, 16'h0001, Z, ST, OK, OK}, '{C_GET_TS, Z, Z, W1, OK, 16'h0001},
            '{C_SET_LPI, 16'h00BD, Z, ST, OK, OK}, '{C_GET_LPI, Z, Z, W1, OK, 16'h00B1},
            '{C_SET_EMI, 16'h0001, Z, ST, OK, OK}, '{C_GET_EMI, Z, Z, W1, OK, 16'h0001},
            '{C_ENA_F2I, Z, Z, ST, OK, OK}, '{C_GET_F2I, Z, Z, W1, OK, 16'h0001},
            '{C_DIS_F2I, Z, Z, ST, OK, OK}, '{C_GET_F2I, Z, Z, W1, OK, Z},
            '{C_SET_BP, 16'h0001, Z, ST, OK, OK}, '{C_GET_BP, Z, Z, W1, OK, 16'h0001},
            '{C_SET_LR, 16'h0001, 16'h0001, ST, OK, OK},
            '{C_GET_LR, Z, Z, W2, OK, 16'h0001},
            '{C_SET_UPW, 16'h0123, Z, ST, OK, OK}, '{C_GET_UPW, Z, Z, W1, OK, 16'h0123},
            '{C_GET_TEMP, Z, Z, W1, OK, 16'h0042},
            '{C_GET_VOLT, Z, Z, W3, OK, 16'h0377},
            '{C_GET_SNR, Z, Z, ADDR_WORD5, OK, 16'h0004},
            '{C_GET_SNR, 16'h0001, Z, ST, NG, NG},
            '{16'h8002, Z, Z, ST, NG, NG},
            '{C_SET_TAPS, 16'h0001, 16'hA55A, ST, OK, OK}};
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        `CHK("reset map", MAP_ODD_RST, lane_map)
        mbox_host_i.xfer(ST, 1'b0, Z, q);
        `CHK("reset status", OK, q)
        foreach (rows[i]) begin
            mbox_host_i.run_cmd(rows[i].cmd, rows[i].w1, rows[i].w2, q);
            `CHK("status", rows[i].st, q)
            mbox_host_i.xfer(rows[i].adr, 1'b0, Z, q);
            `CHK("word", rows[i].exp, q)
        end
        `CHK("ts before autoneg", 1'b0, ts_en)
        `CHK("limited reach", 1'b1, lr_en)
        `CHK("second port taps", 16'hA55A, taps1.pre_main)
        `CHK("warn bound", 16'h0123, temp_warn)
        // link restart after the settings were written
        autoneg <= 1'b1;
        repeat (4) @(posedge core_clk);
        autoneg <= 1'b0;
        repeat (4) @(posedge core_clk);
        `CHK("ts applied", 1'b1, ts_en)
        `CHK("emi applied", 1'b1, emi_en)
        `CHK("map applied", 8'h39, lane_map)
        `CHK("modes applied", 8'hB1, lpi_cfg.modes)
        `CHK("fault idle", 1'b0, fault_idle)
        `CHK("backplane", 1'b1, backplane)
        mbox_host_i.xfer(6'h3C, 1'b0, Z, q);
        `CHK("unmapped", Z, q)
        training <= 1'b1;
        repeat (4) @(posedge core_clk);
        mbox_host_i.xfer(ST, 1'b0, Z, q);
        `CHK("busy", ST_BUSY, q)
        training <= 1'b0;
        close_out();
    end
endmodule : phy_mailbox_command_params_bench
